/* File: hw/qcpc_top.sv */
// Four 8-bit counters with chaining, two PWM outputs and pair capture.
// Assumes an AXI4-Lite master on sys_clk; pins and clock inputs are async.
//
// Behaviour
// R1 - Four 8-bit counters; each pair may chain into one 16-bit counter.
// R2 - Two PWM outputs on two port pins, width 8 to 16 bits.
// R3 - Capture only on first pair, one shared internal or external signal.
// R4 - Capture works with first pair split or chained.
// R5 - First pair split: counters, captured counters, or PWM plus captured.
// R6 - Second pair split: two counters, or PWM plus counter.
// R7 - First pair write sets compare; read gives count or captured count.
// R8 - Second pair write sets compare; read always gives live count.
// R9 - Clock select: two bits per counter, fourth highest, first lowest.
// R10 - Direction bits 7..4 in config one; zero counts down, one up.
// R11 - Chain bits: bit 3 second pair, bit 2 first pair.
// R12 - Bit 0 drives first PWM pin, bit 1 drives second PWM pin.
// R13 - Config two: capture source bits 7-6, capture function bits 5-4.
// R14 - Config two: PWM widths, second in bits 3-2, first in 1-0.
// R15 - Bits 7..4 halve each counter's pin clock when set.
// R16 - Enable bits 3..0; a counter advances only while enabled.
// R17 - Capture on rising, falling or both edges; crystal only rising.
// R18 - Chained pair follows enable of its low counter.
// R19 - Counter mode write: up clears count, down loads compare.
// R20 - Event when count reaches compare, or on capture in capture mode.
// R21 - Global reset clears counts, compares, selects, config, enables.
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps

module qcpc_top (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // AXI4-Lite write address and data
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Counter clock and capture sources
  input  wire logic [3:0]  clock_input_pins,
  input  wire logic [2:0]  int_clk_src,
  input  wire logic [3:0]  capture_src,
  // PWM pins and counter events
  output logic             pwm_pin0,
  output logic             pwm_pin0_oe,
  output logic             pwm_pin1,
  output logic             pwm_pin1_oe,
  output logic [3:0]       event_out
);

  // Reset release
  logic [1:0]  rst_sync_q;
  logic        rst_sync_b;

  // Input synchronisers
  logic [10:0] in_s1_q;
  logic [10:0] in_s2_q;
  logic [3:0]  pin_s;
  logic [2:0]  int_s;
  logic [3:0]  cap_s;

  // Bus state
  logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic        awready_q, awready_d, wready_q, wready_d;
  logic        bvalid_q, bvalid_d, arready_q, arready_d;
  logic        rvalid_q, rvalid_d, wstrb_q, wstrb_d;
  logic        wr_fire, wr_hit;
  logic [4:0]  awaddr_q, awaddr_d;
  logic [7:0]  wdata_q, wdata_d, rdata_q, rdata_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;

  // Register file and counter state
  logic [7:0]  cmp_q [4], cmp_d [4], cnt_q [4], cnt_d [4];
  logic [7:0]  capt_q [2], capt_d [2];
  logic [7:0]  clk_sel_q, clk_sel_d, cfg1_q, cfg1_d;
  logic [7:0]  cfg2_q, cfg2_d, run_reg_q, run_reg_d;
  logic [3:0]  pin_prev_q, pin_prev_d, tog_q, tog_d;
  logic [3:0]  lvl_prev_q, lvl_prev_d, evt_q, evt_d;
  logic        cap_prev_q, cap_prev_d, pwm0_q, pwm0_d, pwm1_q, pwm1_d;
  logic        pwm0_oe_q, pwm0_oe_d, pwm1_oe_q, pwm1_oe_d;

  // Decoded control
  logic [3:0]  lvl, tick, run, dir, ev;
  logic [1:0]  chain, pwm_on;
  logic [1:0]  ck_sel, cap_sel;
  logic        cap_on, cap_lvl, cap_evt, use_rise, use_fall;
  qcpc_pkg::qcpc_cap_fn_t cap_fn;
  qcpc_pkg::qcpc_step_t   st;
  logic [15:0] mask;

  // Reset release through two flops
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_sync_b = rst_sync_q[1];

  // Two-flop synchronisers for pins, clocks and capture sources
  always_ff @(posedge sys_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      in_s1_q <= 11'h000;
      in_s2_q <= 11'h000;
    end
    else
    begin
      in_s1_q <= {capture_src, int_clk_src, clock_input_pins};
      in_s2_q <= in_s1_q;
    end
  end
  assign pin_s = in_s2_q[3:0];
  assign int_s = in_s2_q[6:4];
  assign cap_s = in_s2_q[10:7];

  // Write fires once address and data are both held
  assign wr_fire = aw_have_q & w_have_q & ~bvalid_q;
  assign wr_hit  = wr_fire & wstrb_q;

  // AXI4-Lite slave next state
  always_comb
  begin
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    if (s_axi_awvalid && awready_q)
    begin
      aw_have_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q)
    begin
      w_have_d = 1'b1;
      wdata_d  = s_axi_wdata[7:0];
      wstrb_d  = s_axi_wstrb[0];
    end
    if (wr_fire)
    begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = awaddr_q[1:0] == 2'h0 ? qcpc_pkg::RESP_OKAY
                                         : qcpc_pkg::RESP_SLVERR;
    end
    else if (bvalid_q && s_axi_bready)
      bvalid_d = 1'b0;
    if (s_axi_arvalid && arready_q)
    begin
      rvalid_d = 1'b1;
      rresp_d  = qcpc_pkg::RESP_OKAY;
      case (s_axi_araddr)
        qcpc_pkg::OFS_CNT_A: rdata_d = cap_on ? capt_q[0] : cnt_q[0]; // R7
        qcpc_pkg::OFS_CNT_B: rdata_d = cap_on ? capt_q[1] : cnt_q[1]; // R7
        qcpc_pkg::OFS_CNT_C: rdata_d = cnt_q[2]; // R8
        qcpc_pkg::OFS_CNT_D: rdata_d = cnt_q[3]; // R8
        qcpc_pkg::OFS_CLK_SEL: rdata_d = clk_sel_q;
        qcpc_pkg::OFS_CFG1: rdata_d = cfg1_q;
        qcpc_pkg::OFS_CFG2: rdata_d = cfg2_q;
        qcpc_pkg::OFS_RUN: rdata_d = run_reg_q;
        default:
        begin
          rdata_d = 8'h00;
          rresp_d = qcpc_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_d = 1'b0;
    awready_d = ~aw_have_d & ~bvalid_d;
    wready_d  = ~w_have_d & ~bvalid_d;
    arready_d = ~rvalid_d;
  end

  // AXI4-Lite slave registers
  always_ff @(posedge sys_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      {aw_have_q, w_have_q, wstrb_q, awready_q, wready_q, bvalid_q,
       arready_q, rvalid_q} <= 8'h00;
      {awaddr_q, wdata_q, bresp_q, rresp_q, rdata_q} <= 25'h0;
    end
    else
    begin
      {aw_have_q, w_have_q, awaddr_q, wdata_q, wstrb_q, awready_q,
       wready_q, bvalid_q, bresp_q} <= {aw_have_d, w_have_d, awaddr_d,
       wdata_d, wstrb_d, awready_d, wready_d, bvalid_d, bresp_d};
      {arready_q, rvalid_q, rresp_q, rdata_q} <= {arready_d, rvalid_d,
                                                  rresp_d, rdata_d};
    end
  end

  // Control decode, clock selection and capture edge
  always_comb
  begin
    chain   = cfg1_q[qcpc_pkg::CFG1_CHAIN +: 2]; // R11
    pwm_on  = cfg1_q[qcpc_pkg::CFG1_PWM +: 2]; // R12
    dir     = cfg1_q[qcpc_pkg::CFG1_DIR +: 4]; // R10
    cap_sel = cfg2_q[qcpc_pkg::CFG2_CAP_SEL +: 2]; // R13
    cap_fn  = qcpc_pkg::qcpc_cap_fn_t'(cfg2_q[qcpc_pkg::CFG2_CAP_FN +: 2]);
    cap_on  = cap_fn != qcpc_pkg::QCPC_CAP_OFF; // R13
    ck_sel  = 2'h0;
    for (int i = 0; i < 4; i++)
    begin
      ck_sel = clk_sel_q[2*i +: 2]; // R9
      if (ck_sel == qcpc_pkg::CK_SEL_PIN)
        lvl[i] = run_reg_q[qcpc_pkg::RUN_HALVE + i] ? tog_q[i]
                                                    : pin_s[i]; // R15
      else
        lvl[i] = int_s[2'(ck_sel - 2'h1)];
      tick[i] = lvl[i] & ~lvl_prev_q[i];
      run[i]  = run_reg_q[qcpc_pkg::RUN_EN + i]; // R16
    end
    run[1] = chain[0] ? run[0] : run[1]; // R18
    run[3] = chain[1] ? run[2] : run[3]; // R18
    cap_lvl  = cap_s[cap_sel]; // R3
    use_rise = cap_on && (cap_fn != qcpc_pkg::QCPC_CAP_FALL
                          || cap_sel == qcpc_pkg::CAP_SRC_XTAL); // R17
    use_fall = (cap_fn == qcpc_pkg::QCPC_CAP_FALL
                || cap_fn == qcpc_pkg::QCPC_CAP_BOTH)
               && cap_sel != qcpc_pkg::CAP_SRC_XTAL; // R17
    cap_evt  = (use_rise & cap_lvl & ~cap_prev_q)
             | (use_fall & ~cap_lvl & cap_prev_q);
  end

  // Counter, capture, PWM and register write next state
  always_comb
  begin
    cnt_d      = cnt_q;
    cmp_d      = cmp_q;
    capt_d     = capt_q;
    clk_sel_d  = clk_sel_q;
    cfg1_d     = cfg1_q;
    cfg2_d     = cfg2_q;
    run_reg_d  = run_reg_q;
    pin_prev_d = pin_s;
    tog_d      = tog_q ^ (pin_s & ~pin_prev_q);
    lvl_prev_d = lvl;
    cap_prev_d = cap_lvl;
    ev         = 4'h0;
    st         = '0;
    mask       = qcpc_pkg::MASK8;
    // Each pair counts as 16 bits or as two 8-bit counters
    for (int p = 0; p < 2; p++)
    begin
      if (chain[p]) // R1
      begin
        mask = pwm_on[p] ? qcpc_pkg::qcpc_wmask(cfg2_q[2*p +: 2]) // R14
                         : qcpc_pkg::MASK16;
        st = qcpc_pkg::qcpc_step({cnt_q[2*p+1], cnt_q[2*p]},
                                 {cmp_q[2*p+1], cmp_q[2*p]},
                                 mask, dir[2*p], pwm_on[p]);
        if (run[2*p] && tick[2*p]) // R16
        begin
          cnt_d[2*p]   = st.val[7:0];
          cnt_d[2*p+1] = st.val[15:8];
          ev[2*p]      = st.ev; // R20
        end
      end
      else
      begin
        for (int k = 0; k < 2; k++)
        begin
          st = qcpc_pkg::qcpc_step({8'h00, cnt_q[2*p+k]},
                                   {8'h00, cmp_q[2*p+k]},
                                   qcpc_pkg::MASK8, dir[2*p+k],
                                   pwm_on[p] && k == 0); // R5 R6
          if (run[2*p+k] && tick[2*p+k]) // R16
          begin
            cnt_d[2*p+k] = st.val[7:0];
            ev[2*p+k]    = st.ev; // R20
          end
        end
      end
    end
    // Capture latches both first-pair counters together
    if (cap_on && cap_evt) // R3 R4
    begin
      capt_d[0] = cnt_q[0];
      capt_d[1] = cnt_q[1];
    end
    if (cap_on) // R20
    begin
      ev[0] = cap_evt;
      ev[1] = cap_evt;
    end
    // Register writes; counter mode also reloads the count
    if (wr_hit)
    begin
      case (awaddr_q)
        qcpc_pkg::OFS_CLK_SEL: clk_sel_d = wdata_q; // R9
        qcpc_pkg::OFS_CFG1: cfg1_d = wdata_q; // R10 R11 R12
        qcpc_pkg::OFS_CFG2: cfg2_d = wdata_q; // R13 R14
        qcpc_pkg::OFS_RUN: run_reg_d = wdata_q; // R15 R16
        default:
        begin
          for (int j = 0; j < 4; j++)
          begin
            if (awaddr_q == 5'(4 * j))
            begin
              cmp_d[j] = wdata_q; // R7 R8
              if (!pwm_on[j/2] || (j % 2 == 1 && !chain[j/2]))
              begin
                if (!(cap_on && j < 2))
                  cnt_d[j] = dir[j] ? 8'h00 : wdata_q; // R19
              end
            end
          end
        end
      endcase
    end
    evt_d = ev; // R20
    // PWM high while the count is below the compare value
    pwm0_oe_d = pwm_on[0]; // R2 R12
    pwm1_oe_d = pwm_on[1]; // R2 R12
    mask = chain[0] ? qcpc_pkg::qcpc_wmask(cfg2_q[1:0]) : qcpc_pkg::MASK8;
    pwm0_d = pwm_on[0] && (({cnt_q[1], cnt_q[0]} & mask)
                           < ({cmp_q[1], cmp_q[0]} & mask)); // R2
    mask = chain[1] ? qcpc_pkg::qcpc_wmask(cfg2_q[3:2]) : qcpc_pkg::MASK8;
    pwm1_d = pwm_on[1] && (({cnt_q[3], cnt_q[2]} & mask)
                           < ({cmp_q[3], cmp_q[2]} & mask)); // R2
  end

  // Counter and register state
  always_ff @(posedge sys_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b) // R21
    begin
      cnt_q  <= '{default: qcpc_pkg::REG_RST};
      cmp_q  <= '{default: qcpc_pkg::REG_RST};
      capt_q <= '{default: qcpc_pkg::REG_RST};
      {clk_sel_q, cfg1_q, cfg2_q, run_reg_q} <= {4{qcpc_pkg::REG_RST}};
      {pin_prev_q, tog_q, lvl_prev_q, evt_q} <= 16'h0000;
      {cap_prev_q, pwm0_q, pwm1_q, pwm0_oe_q, pwm1_oe_q} <= 5'h00;
    end
    else
    begin
      cnt_q      <= cnt_d;
      cmp_q      <= cmp_d;
      capt_q     <= capt_d;
      clk_sel_q  <= clk_sel_d;
      cfg1_q     <= cfg1_d;
      cfg2_q     <= cfg2_d;
      run_reg_q  <= run_reg_d;
      pin_prev_q <= pin_prev_d;
      tog_q      <= tog_d;
      lvl_prev_q <= lvl_prev_d;
      cap_prev_q <= cap_prev_d;
      evt_q      <= evt_d;
      pwm0_q     <= pwm0_d;
      pwm1_q     <= pwm1_d;
      pwm0_oe_q  <= pwm0_oe_d;
      pwm1_oe_q  <= pwm1_oe_d;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = {24'h000000, rdata_q};
  assign pwm_pin0      = pwm0_q;
  assign pwm_pin0_oe   = pwm0_oe_q;
  assign pwm_pin1      = pwm1_q;
  assign pwm_pin1_oe   = pwm1_oe_q;
  assign event_out     = evt_q;

endmodule

/* File: hw/qcpc_pkg.sv */
// Package for the quad counter, PWM and capture block.
// Assumes a 32-bit AXI4-Lite register bus, one register per word.
package qcpc_pkg;

  // Register byte offsets
  localparam int unsigned ADDR_W = 5;
  localparam logic [4:0] OFS_CNT_A   = 5'h00;
  localparam logic [4:0] OFS_CNT_B   = 5'h04;
  localparam logic [4:0] OFS_CNT_C   = 5'h08;
  localparam logic [4:0] OFS_CNT_D   = 5'h0C;
  localparam logic [4:0] OFS_CLK_SEL = 5'h10;
  localparam logic [4:0] OFS_CFG1    = 5'h14;
  localparam logic [4:0] OFS_CFG2    = 5'h18;
  localparam logic [4:0] OFS_RUN     = 5'h1C;

  // Reset value of every register field
  localparam logic [7:0] REG_RST = 8'h00;

  // Field positions, configuration one
  localparam int unsigned CFG1_DIR   = 4;
  localparam int unsigned CFG1_CHAIN = 2;
  localparam int unsigned CFG1_PWM   = 0;

  // Field positions, configuration two
  localparam int unsigned CFG2_CAP_SEL = 6;
  localparam int unsigned CFG2_CAP_FN  = 4;
  localparam int unsigned CFG2_PWM_W   = 0;

  // Field positions, enable and halve register
  localparam int unsigned RUN_HALVE = 4;
  localparam int unsigned RUN_EN    = 0;

  // Clock source code for the port pin of each counter
  localparam logic [1:0] CK_SEL_PIN = 2'h0;

  // Capture source code of the 32 kHz crystal clock
  localparam logic [1:0] CAP_SRC_XTAL = 2'h3;

  // Capture edge functions
  typedef enum logic [1:0] {
    QCPC_CAP_OFF  = 2'h0,
    QCPC_CAP_RISE = 2'h1,
    QCPC_CAP_FALL = 2'h2,
    QCPC_CAP_BOTH = 2'h3
  } qcpc_cap_fn_t;

  // Count masks and PWM width shift (code 0 = 10 bits)
  localparam logic [15:0] MASK8  = 16'h00FF;
  localparam logic [15:0] MASK16 = 16'hFFFF;
  localparam logic [3:0]  PWM_SHIFT_MAX = 4'h6;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Result of one counting step
  typedef struct packed {
    logic        ev;
    logic [15:0] val;
  } qcpc_step_t;

  // One counting step; pwm wraps freely, else compare/reload
  function automatic qcpc_step_t qcpc_step(
    input logic [15:0] cnt,
    input logic [15:0] cmp,
    input logic [15:0] mask,
    input logic        up,
    input logic        pwm
  );
    qcpc_step_t r;
    r.ev  = 1'b0;
    r.val = cnt;
    if (pwm)
    begin
      r.val = (up ? cnt + 16'h0001 : cnt - 16'h0001) & mask;
    end
    else if (up)
    begin
      r.ev  = (cnt == cmp);
      r.val = r.ev ? 16'h0000 : (cnt + 16'h0001) & mask;
    end
    else
    begin
      r.ev  = (cnt == 16'h0000);
      r.val = r.ev ? cmp : (cnt - 16'h0001) & mask;
    end
    return r;
  endfunction

  // PWM width mask from a 2-bit width code
  function automatic logic [15:0] qcpc_wmask(input logic [1:0] code);
    logic [3:0] sh;
    sh = PWM_SHIFT_MAX - {1'b0, code, 1'b0};
    return MASK16 >> sh;
  endfunction

endpackage

/* File: testbench/qcpc_monitor.sv */
// Checker for the bus handshakes and event pulses of the counter block.
// Assumes it is bound onto qcpc_top and sees only its ports.
`timescale 1ns/10ps

module qcpc_monitor (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_b,
  // Write channels
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Read channels
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Counter events
  input wire logic [3:0]  event_out
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  // Handshake steps
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wr_hold;
    !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  // Write answer two edges after both halves are taken
  wr_resp_time_a: assert property (wr_taken |=> wr_hold ##1 s_axi_bvalid)
    else $error("write response not on time");
  wr_resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  wr_resp_end_a: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid)
    else $error("write response held after ready");
  // Read answer one edge after address
  rd_resp_time_a: assert property (rd_taken |=> s_axi_rvalid
    && !s_axi_arready)
    else $error("read data not on time");
  rd_data_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data changed before ready");
  rd_resp_end_a: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid)
    else $error("read data held after ready");
  rd_byte_only_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data above byte lane");
  rd_err_zero_a: assert property (s_axi_rvalid && s_axi_rresp
    != qcpc_pkg::RESP_OKAY |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  event_pulse_a: assert property (|event_out |=> event_out == 4'h0)
    else $error("event longer than one cycle");
endmodule

bind qcpc_top qcpc_monitor mon (
  .sys_clk, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .event_out
);

/* File: testbench/tb.sv */
// Self-checking bench for the quad counter, PWM and capture block.
// Assumes qcpc_top with its checker bound; the bench drives every input port.
`timescale 1ns/10ps

`define CHK(g, e) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end

module tb;
  logic        sys_clk;
  logic        rst_b;
  logic [4:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [4:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic [10:0] srcs;
  wire  [3:0]  clock_input_pins = srcs[3:0];
  wire  [2:0]  int_clk_src      = srcs[6:4];
  wire  [3:0]  capture_src      = srcs[10:7];
  logic        pwm_pin0;
  logic        pwm_pin0_oe;
  logic        pwm_pin1;
  logic        pwm_pin1_oe;
  logic [3:0]  event_out;
  logic [31:0] rv;
  logic [1:0]  rr;
  int          n_errors = 0;
  int          total_checks = 0;
  int          ev[4] = '{0, 0, 0, 0};
  int          e1;
  int          i;

  qcpc_top uut (
    .sys_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .clock_input_pins, .int_clk_src,
    .capture_src, .pwm_pin0, .pwm_pin0_oe, .pwm_pin1, .pwm_pin1_oe,
    .event_out
  );

  // 25 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Tally event pulses per counter
  always @(posedge sys_clk)
    for (int k = 0; k < 4; k++)
      if (event_out[k] === 1'b1)
        ev[k] <= ev[k] + 1;

  // Register write, address and data offered together
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    // Each channel released at the edge that takes it
    do
    begin
      @(posedge sys_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready)
               || (s_axi_wvalid && !s_axi_wready));
    while (!s_axi_bvalid)
      @(posedge sys_clk);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Register read
  task automatic rd(input logic [4:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    @(posedge sys_clk);
    while (!s_axi_arready)
      @(posedge sys_clk);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid)
      @(posedge sys_clk);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Read and compare one byte register
  task automatic ck(input logic [4:0] a, input logic [7:0] e);
    rd(a);
    `CHK(rv, {24'h0, e})
  endtask

  // Pulses on one source line, each 3 cycles high and 3 low
  task automatic tick(input int k, input int n);
    repeat (n)
    begin
      srcs[k] <= 1'b1;
      repeat (3) @(posedge sys_clk);
      srcs[k] <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
    repeat (4) @(posedge sys_clk);
  endtask

  // Verdict and end of run
  task automatic results();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    #2000000;
    n_errors++;
    results();
  end

  // Main sequence
  initial
  begin
    rst_b = 1'b0;
    srcs = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    for (i = 0; i < 8; i++)
      ck(5'(i * 4), 8'h00);
    rd(5'h02);
    `CHK(rr, qcpc_pkg::RESP_SLVERR)
    wr(5'h03, 8'h11);
    `CHK(rr, qcpc_pkg::RESP_SLVERR)
    // Byte lane strobe low: accepted, no effect
    s_axi_wstrb <= 4'hE;
    wr(qcpc_pkg::OFS_CFG2, 8'h55);
    s_axi_wstrb <= 4'hF;
    `CHK(rr, qcpc_pkg::RESP_OKAY)
    ck(qcpc_pkg::OFS_CFG2, 8'h00);
    wr(qcpc_pkg::OFS_CLK_SEL, 8'hE4);
    ck(qcpc_pkg::OFS_CLK_SEL, 8'hE4);
    wr(qcpc_pkg::OFS_CFG2, 8'hA5);
    ck(qcpc_pkg::OFS_CFG2, 8'hA5);
    wr(qcpc_pkg::OFS_CFG2, 8'h00);
    wr(qcpc_pkg::OFS_CLK_SEL, 8'h00);
    wr(5'h14, 8'hF0);
    ck(5'h14, 8'hF0);
    // All four counters up to a compare of 2
    for (i = 0; i < 4; i++)
      wr(5'(i * 4), 8'h02);
    wr(5'h1C, 8'h0F);
    ck(5'h1C, 8'h0F);
    for (i = 0; i < 4; i++)
    begin
      tick(i, 2);
      ck(5'(i * 4), 8'h02);
      tick(i, 1);
      `CHK(ev[i], 1)
      ck(5'(i * 4), 8'h00);
    end
    wr(5'h1C, 8'h00);
    tick(0, 2);
    ck(5'h00, 8'h00);
    // Down count loads compare on write
    wr(5'h14, 8'hE0);
    wr(5'h00, 8'h05);
    ck(5'h00, 8'h05);
    wr(5'h1C, 8'h01);
    tick(0, 1);
    ck(5'h00, 8'h04);
    // Halved pin clock
    wr(5'h14, 8'hF0);
    wr(5'h00, 8'h09);
    wr(5'h1C, 8'h11);
    tick(0, 4);
    ck(5'h00, 8'h02);
    // Internal clock code 1, pin ignored
    wr(5'h1C, 8'h01);
    wr(5'h10, 8'h01);
    wr(5'h00, 8'h09);
    tick(4, 2);
    tick(0, 2);
    ck(5'h00, 8'h02);
    wr(5'h10, 8'h00);
    // First pair chained, run by the low counter only
    wr(5'h14, 8'hF4);
    wr(5'h04, 8'h01);
    wr(5'h00, 8'hFF);
    tick(0, 256);
    ck(5'h00, 8'h00);
    ck(5'h04, 8'h01);
    // Capture on the first pair
    wr(5'h14, 8'hF0);
    wr(5'h00, 8'h14);
    wr(5'h18, 8'h10);
    tick(0, 3);
    e1 = ev[1];
    tick(7, 1);
    tick(0, 2);
    ck(5'h00, 8'h03);
    ck(5'h04, 8'h01);
    `CHK(ev[1] - e1, 1)
    wr(5'h18, 8'h30);
    e1 = ev[1];
    tick(7, 1);
    `CHK(ev[1] - e1, 2)
    wr(5'h18, 8'hF0);
    e1 = ev[1];
    tick(10, 1);
    `CHK(ev[1] - e1, 1)
    wr(5'h18, 8'h20);
    e1 = ev[1];
    tick(7, 1);
    `CHK(ev[1] - e1, 1)
    // Capture of the chained first pair
    wr(5'h14, 8'hF4);
    wr(5'h18, 8'h10);
    tick(0, 1);
    tick(7, 1);
    tick(0, 1);
    ck(5'h00, 8'h06);
    ck(5'h04, 8'h01);
    // PWM outputs
    wr(5'h18, 8'h00);
    wr(5'h14, 8'h13);
    repeat (2) @(posedge sys_clk);
    `CHK(pwm_pin0_oe, 1'b1)
    `CHK(pwm_pin1_oe, 1'b1)
    `CHK(pwm_pin0, 1'b1)
    `CHK(pwm_pin1, 1'b1)
    results();
  end
endmodule
